/* File: src/scm_clock_modes.sv */
// System clock selection, clock ticks and operating-mode control.
// Oscillators arrive as free-running pins sampled on aclk; every derived
// clock leaves as a one-cycle tick on aclk. Core supplies halt and wake.
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "scm_defines.svh"

module scm_clock_modes #(
    parameter int ADDR_W = 4
) (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic               high_osc,
    input  wire logic               low_osc,
    input  wire logic               cfg_high_is_rc,
    input  wire logic               cfg_low_is_crystal,
    input  wire logic               halt_req,
    input  wire logic               wake_req,
    output logic                    high_osc_enable,
    output scm_pkg::scm_mode_t      mode,
    output scm_pkg::scm_ticks_t     ticks,
    input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [ADDR_W-1:0]  s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready
);
    import scm_pkg::*;

    // Offsets need four address bits
    if (ADDR_W < 4) begin : g_chk
        $error("scm_clock_modes: ADDR_W must be at least 4");
    end

    scm_state_t r;
    scm_state_t n;

    // Mask of divider count bits that must be all ones for one tick
    function automatic logic [5:0] div_mask(input logic [2:0] cks);
        logic [5:0] m;
        m = 6'h01;
        case (cks)
            3'h2:    m = 6'h3f; // /64
            3'h3:    m = 6'h1f; // /32
            3'h4:    m = 6'h0f; // /16
            3'h5:    m = 6'h07; // /8
            3'h6:    m = 6'h03; // /4
            default: m = 6'h01; // /2
        endcase
        return m;
    endfunction : div_mask

    // Register read decode
    function automatic logic [31:0] rd_word(input scm_state_t s,
                                           input logic [3:0] a);
        logic [31:0] d;
        d = 32'h0;
        case (a)
            `SCM_OFS_MODE: begin
                d[`SCM_CKS_LSB+:3] = s.cks;
                d[`SCM_BIT_FSTEN]  = s.fsten;
                d[`SCM_BIT_LRDY]   = s.lrdy;
                d[`SCM_BIT_HRDY]   = s.hrdy;
                d[`SCM_BIT_IDLE_ON_HALT_ENABLE]  = s.idle_on_halt_enable;
                d[`SCM_BIT_HLSEL]  = s.hlsel;
            end
            `SCM_OFS_CTRL: d[`SCM_BIT_SYSCLK_IN_IDLE_ENABLE] = s.sysclk_in_idle_enable;
            `SCM_OFS_STAT: begin
                d[5:0]  = s.mode;
                d[10:8] = s.src;
                d[12]   = s.hosc_en;
                d[13]   = s.fast;
            end
            default: d = 32'h0;
        endcase
        return d;
    endfunction : rd_word

    function automatic logic mapped(input logic [3:0] a);
        return a == `SCM_OFS_MODE || a == `SCM_OFS_CTRL ||
               a == `SCM_OFS_STAT;
    endfunction : mapped

    logic       h_raw;
    logic       l_edge;
    logic       h_edge;
    logic       div_tick;
    logic       src_tick;
    scm_src_t   want_src;
    logic [5:0] want_mask;
    scm_mode_t  run_mode;
    logic       running;
    logic       sys_tick;
    logic [7:0] h_lim;
    logic [7:0] l_lim;
    logic [3:0] wa;
    logic [3:0] ra;

    always_comb begin
        n = r;
        wa = s_axi_awaddr[3:0];
        ra = s_axi_araddr[3:0];

        // Two-flop synchronisers; third stage only for edge finding
        n.h1 = high_osc;
        n.h2 = r.h1;
        n.h3 = r.h2;
        n.l1 = low_osc;
        n.l2 = r.l1;
        n.l3 = r.l2;
        n.c1 = cfg_high_is_rc;
        n.c2 = r.c1;
        n.x1 = cfg_low_is_crystal;
        n.x2 = r.x1;

        h_raw  = r.h2 & ~r.h3;
        h_edge = h_raw & r.hosc_en;
        l_edge = r.l2 & ~r.l3;

        // Settle counts follow the strapped oscillator kinds
        h_lim = r.c2 ? `SCM_HIGH_RC_OSC_SETTLE : `SCM_HXT_SETTLE;
        l_lim = r.x2 ? `SCM_LXT_SETTLE : `SCM_LOW_RC_OSC_SETTLE;

        // High oscillator ready flag, lost whenever it is stopped
        if (!r.hosc_en) begin
            n.hcnt = 8'h00;
            n.hrdy = 1'b0;
        end else if (h_raw && !r.hrdy) begin
            n.hcnt = r.hcnt + 8'h01;
            if (r.hcnt == h_lim - 8'h01) n.hrdy = 1'b1;
        end
        // Low oscillator never stops, so its flag sticks once set
        if (l_edge && !r.lrdy) begin
            n.lcnt = r.lcnt + 8'h01;
            if (r.lcnt == l_lim - 8'h01) n.lrdy = 1'b1;
        end

        // Divided high clock
        if (h_edge) n.div_cnt = r.div_cnt + 6'h01;
        div_tick = h_edge && ((r.div_cnt & r.mask) == r.mask);

        case (r.src)
            SRC_LOW:  src_tick = l_edge;
            SRC_FULL: src_tick = h_edge;
            SRC_DIV:  src_tick = div_tick;
            default:  src_tick = 1'b0;
        endcase

        // Requested source from select bit and divider code
        want_mask = div_mask(r.cks);
        if (r.hlsel) want_src = SRC_FULL;
        else if (r.cks < 3'h2) want_src = SRC_LOW;
        else want_src = SRC_DIV;

        case (r.src)
            SRC_LOW:  run_mode = MODE_SLOW_LOW_CLOCK_MODE;
            SRC_FULL: run_mode = MODE_NORMAL;
            default:  run_mode = MODE_SLOW_DIVIDED_CLOCK_MODE;
        endcase
        running = r.mode == MODE_NORMAL || r.mode == MODE_SLOW_LOW_CLOCK_MODE ||
                  r.mode == MODE_SLOW_DIVIDED_CLOCK_MODE;

        // Change source only at a tick of the old one, or at once off an unsettled
        // high clock, and only onto a settled high clock, so no runt period reaches the core
        if (running && (want_src != r.src || want_mask != r.mask) &&
            (src_tick || (r.src != SRC_LOW && !r.hrdy)) &&
            (want_src == SRC_LOW || r.hrdy)) begin
            n.src = want_src;
            n.mask = want_mask;
            n.div_cnt = 6'h00;
        end

        // High oscillator runs only while something uses it
        if (running)
            n.hosc_en = want_src != SRC_LOW || n.src != SRC_LOW;
        else if (r.mode == MODE_IDLE_CLOCK_RUNNING_MODE)
            n.hosc_en = r.src != SRC_LOW;
        else
            n.hosc_en = 1'b0;

        // Operating mode
        case (r.mode)
            MODE_NORMAL, MODE_SLOW_LOW_CLOCK_MODE, MODE_SLOW_DIVIDED_CLOCK_MODE: begin
                if (halt_req) begin
                    if (!r.idle_on_halt_enable) n.mode = MODE_SLEEP;
                    else if (r.sysclk_in_idle_enable) n.mode = MODE_IDLE_CLOCK_RUNNING_MODE;
                    else n.mode = MODE_IDLE_CLOCKS_STOPPED_MODE;
                end else begin
                    n.mode = run_mode;
                end
            end
            MODE_SLEEP, MODE_IDLE_CLOCKS_STOPPED_MODE: begin
                if (wake_req) begin
                    n.mode = run_mode;
                    // Bridge the crystal restart on the substitute clock
                    n.fast = r.fsten && !r.c2 && r.src != SRC_LOW;
                end
            end
            MODE_IDLE_CLOCK_RUNNING_MODE: begin
                if (wake_req) n.mode = run_mode;
            end
            default: n.mode = MODE_NORMAL;
        endcase
        if (r.fast && (r.hrdy || !running)) n.fast = 1'b0;

        // Core waits for a settled high clock unless bridged
        sys_tick = src_tick && (r.src == SRC_LOW || r.hrdy);
        n.tk.cpu = running && (r.fast ? l_edge : sys_tick);
        n.tk.periph = (running || r.mode == MODE_IDLE_CLOCK_RUNNING_MODE) && sys_tick;
        n.tk.sub = l_edge;
        n.tk.tbc = l_edge && r.mode != MODE_SLEEP;

        // Write address and data taken independently
        if (s_axi_awvalid && s_axi_awready) begin
            n.aw_got = 1'b1;
            n.awaddr = wa;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            n.w_got = 1'b1;
            n.wdata = s_axi_wdata[7:0];
            n.wstrb0 = s_axi_wstrb[0];
        end
        if (r.aw_got && r.w_got && !r.bvalid) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = mapped(r.awaddr) ? `SCM_RESP_OKAY : `SCM_RESP_SLVERR;
            if (r.wstrb0 && r.awaddr == `SCM_OFS_MODE) begin
                n.cks = r.wdata[`SCM_CKS_LSB+:3];
                n.fsten = r.wdata[`SCM_BIT_FSTEN];
                n.idle_on_halt_enable = r.wdata[`SCM_BIT_IDLE_ON_HALT_ENABLE];
                n.hlsel = r.wdata[`SCM_BIT_HLSEL];
            end
            if (r.wstrb0 && r.awaddr == `SCM_OFS_CTRL)
                n.sysclk_in_idle_enable = r.wdata[`SCM_BIT_SYSCLK_IN_IDLE_ENABLE];
        end
        if (r.bvalid && s_axi_bready) n.bvalid = 1'b0;

        // Read answers one cycle after the address is taken
        if (s_axi_arvalid && s_axi_arready) begin
            n.rvalid = 1'b1;
            n.rdata = rd_word(r, ra);
            n.rresp = mapped(ra) ? `SCM_RESP_OKAY : `SCM_RESP_SLVERR;
        end else if (r.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
    end

    // State register; high clock starts enabled, full rate selected
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.cks <= 3'(`SCM_MODE_RESET >> `SCM_CKS_LSB);
            r.idle_on_halt_enable <= 1'(`SCM_MODE_RESET >> `SCM_BIT_IDLE_ON_HALT_ENABLE);
            r.hlsel <= 1'(`SCM_MODE_RESET >> `SCM_BIT_HLSEL);
            r.sysclk_in_idle_enable <= 1'(`SCM_CTRL_RESET >> `SCM_BIT_SYSCLK_IN_IDLE_ENABLE);
            r.hosc_en <= 1'b1;
            r.src <= SRC_FULL;
            r.mask <= 6'h01;
            r.mode <= MODE_NORMAL;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from state
    assign high_osc_enable = r.hosc_en;
    assign mode            = r.mode;
    assign ticks           = r.tk;
    assign s_axi_awready   = !r.aw_got && !r.bvalid;
    assign s_axi_wready    = !r.w_got && !r.bvalid;
    assign s_axi_bvalid    = r.bvalid;
    assign s_axi_bresp     = r.bresp;
    assign s_axi_arready   = !r.rvalid;
    assign s_axi_rvalid    = r.rvalid;
    assign s_axi_rdata     = r.rdata;
    assign s_axi_rresp     = r.rresp;

endmodule : scm_clock_modes

/* File: include/scm_defines.svh */
// Register offsets, field positions, reset values and settle counts
// for the system clock and operating-mode controller.
// Assumes inclusion by bare name from the design.
`ifndef SCM_DEFINES_SVH
`define SCM_DEFINES_SVH

`define SCM_OFS_MODE      4'h0
`define SCM_OFS_CTRL      4'h4
`define SCM_OFS_STAT      4'h8

`define SCM_BIT_HLSEL     0
`define SCM_BIT_IDLE_ON_HALT_ENABLE     1
`define SCM_BIT_HRDY      2
`define SCM_BIT_LRDY      3
`define SCM_BIT_FSTEN     4
`define SCM_CKS_LSB       5
`define SCM_BIT_SYSCLK_IN_IDLE_ENABLE    7

`define SCM_MODE_RESET    8'h03
`define SCM_CTRL_RESET    8'h00

`define SCM_HXT_SETTLE    8'h80
`define SCM_HIGH_RC_OSC_SETTLE   8'h10
`define SCM_LXT_SETTLE    8'h80
`define SCM_LOW_RC_OSC_SETTLE   8'h02

`define SCM_RESP_OKAY     2'b00
`define SCM_RESP_SLVERR   2'b10

`endif

/* File: include/scm_pkg.sv */
// Types shared by the clock and operating-mode controller.
// Assumes scm_defines.svh is on the include path.
package scm_pkg;

    // Six operating modes, one-hot
    typedef enum logic [5:0] {
        MODE_NORMAL = 6'b000001,
        MODE_SLOW_LOW_CLOCK_MODE  = 6'b000010,
        MODE_SLOW_DIVIDED_CLOCK_MODE  = 6'b000100,
        MODE_SLEEP  = 6'b001000,
        MODE_IDLE_CLOCKS_STOPPED_MODE  = 6'b010000,
        MODE_IDLE_CLOCK_RUNNING_MODE  = 6'b100000
    } scm_mode_t;

    // System clock source, one-hot
    typedef enum logic [2:0] {
        SRC_LOW  = 3'b001,
        SRC_FULL = 3'b010,
        SRC_DIV  = 3'b100
    } scm_src_t;

    // One-cycle clock ticks handed to the core and peripherals
    typedef struct packed {
        logic cpu;
        logic periph;
        logic sub;
        logic tbc;
    } scm_ticks_t;

    typedef struct packed {
        logic       h1, h2, h3;
        logic       l1, l2, l3;
        logic       c1, c2;
        logic       x1, x2;
        logic [2:0] cks;
        logic       fsten;
        logic       idle_on_halt_enable;
        logic       hlsel;
        logic       sysclk_in_idle_enable;
        logic       hrdy;
        logic       lrdy;
        logic [7:0] hcnt;
        logic [7:0] lcnt;
        logic       hosc_en;
        scm_src_t   src;
        logic [5:0] mask;
        logic [5:0] div_cnt;
        scm_mode_t  mode;
        logic       fast;
        scm_ticks_t tk;
        logic       aw_got;
        logic       w_got;
        logic [3:0] awaddr;
        logic [7:0] wdata;
        logic       wstrb0;
        logic       bvalid;
        logic [1:0] bresp;
        logic       rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } scm_state_t;

endpackage : scm_pkg

/* File: sim/scm_chk.sv */
// Port checker for the clock and operating-mode controller.
// Assumes scm_pkg is compiled first; bound onto scm_clock_modes.
`timescale 1ns/1ps
module scm_chk
    import scm_pkg::*;
(
    input wire logic                aclk,
    input wire logic                aresetn,
    input wire logic                halt_req,
    input wire logic                wake_req,
    input wire logic                high_osc_enable,
    input wire scm_pkg::scm_mode_t  mode,
    input wire scm_pkg::scm_ticks_t ticks
);
    // CPU-off and running groups of the one-hot mode
    wire off = mode[5] | mode[4] | mode[3];
    wire run = mode[2] | mode[1] | mode[0];
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    mode_onehot_a: assert property ($onehot(mode))
        else $error("mode not one-hot");
    halt_enters_off_a: assert property (halt_req && run |=> off)
        else $error("halt did not stop the cpu");
    off_holds_a: assert property (off && !wake_req |=> $stable(mode))
        else $error("off mode left without wake");
    wake_runs_a: assert property (wake_req && off |=> run)
        else $error("wake did not restart the cpu");
    off_no_cpu_a: assert property (off && $past(off) |-> !ticks.cpu)
        else $error("cpu tick in off mode");
    sleep_no_tbc_a: assert property (
        mode == MODE_SLEEP && $past(mode) == MODE_SLEEP |-> !ticks.tbc)
        else $error("time-base tick in sleep");
    hosc_stopped_a: assert property (
        (mode == MODE_IDLE_CLOCKS_STOPPED_MODE || mode == MODE_SLEEP)
        && $stable(mode) |=> !high_osc_enable)
        else $error("high oscillator left running");
    // High clock may warm up in slow mode, but the core stays on low ticks
    slow_low_clock_mode_low_cpu_a: assert property (
        mode == MODE_SLOW_LOW_CLOCK_MODE && ticks.cpu |-> ticks.sub)
        else $error("slow low-clock cpu tick off the low clock");
    tbc_from_low_a: assert property (ticks.tbc |-> ticks.sub)
        else $error("time-base tick without low tick");
    sub_pulse_a: assert property (ticks.sub |=> !ticks.sub)
        else $error("substitute tick too long");

    // Main scenarios reached
    cover property (mode == MODE_SLEEP);
    cover property (mode == MODE_IDLE_CLOCK_RUNNING_MODE && !high_osc_enable);
    cover property (mode == MODE_SLOW_DIVIDED_CLOCK_MODE && ticks.cpu);
endmodule : scm_chk

bind scm_clock_modes scm_chk i_scm_chk (
    .aclk(aclk), .aresetn(aresetn), .halt_req(halt_req),
    .wake_req(wake_req), .high_osc_enable(high_osc_enable),
    .mode(mode), .ticks(ticks));

/* File: sim/scm_osc_model.sv */
// Oscillator pins seen by the controller.
// Assumes the controller's enable gates the high oscillator.
`timescale 1ns/1ps
module scm_osc_model #(
    parameter real HH = 50.0,
    parameter real LH = 500.0
) (
    input  wire logic high_osc_enable,
    output logic      high_osc,
    output logic      low_osc
);
    // Low oscillator runs free, phase unrelated to aclk
    initial begin
        low_osc = 1'b0;
        #7;
        forever #(LH) low_osc = ~low_osc;
    end
    // High oscillator freezes when disabled, like a stopped crystal
    initial high_osc = 1'b0;
    always begin
        #(HH);
        if (high_osc_enable) high_osc = ~high_osc;
    end
endmodule : scm_osc_model

/* File: sim/scm_clock_modes_bench.sv */
// Self-checking bench for the clock and operating-mode controller.
// Assumes scm_pkg, scm_chk and scm_osc_model compiled first.
`timescale 1ns/1ps
module scm_clock_modes_bench;
    import scm_pkg::*;
    logic aclk = 0, aresetn = 0, halt_req = 0, wake_req = 0;
    logic cfg_rc = 1, cfg_lx = 0;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [3:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic awready, wready, bvalid, arready, rvalid, hosc, losc, hen;
    logic [1:0] bresp, rresp;
    scm_mode_t mode, r;
    scm_ticks_t ticks;
    int fails = 0, n_tests = 0, nc, ns, nt, np, c, e, i;
    logic [7:0] tm [4] = '{8'h01, 8'h03, 8'h03, 8'h02};
    logic [7:0] tc [4] = '{8'h00, 8'h00, 8'h80, 8'h80};
    logic th [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    scm_mode_t te [4] = '{MODE_SLEEP, MODE_IDLE_CLOCKS_STOPPED_MODE, MODE_IDLE_CLOCK_RUNNING_MODE, MODE_IDLE_CLOCK_RUNNING_MODE};

    always #12.5 aclk = ~aclk;
    // Tick counters, cleared off the clock edge
    always @(posedge aclk) begin
        nc += ticks.cpu;
        ns += ticks.sub;
        nt += ticks.tbc;
        np += ticks.periph;
    end

    scm_osc_model i_scm_osc_model (.high_osc_enable(hen),
        .high_osc(hosc), .low_osc(losc));
    scm_clock_modes i_scm_clock_modes (.aclk(aclk), .aresetn(aresetn),
        .high_osc(hosc), .low_osc(losc), .cfg_high_is_rc(cfg_rc),
        .cfg_low_is_crystal(cfg_lx), .halt_req(halt_req),
        .wake_req(wake_req), .high_osc_enable(hen), .mode(mode),
        .ticks(ticks), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    task results;
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results

    task chk(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task tmo(input logic ok);
        if (ok !== 1'b1) begin
            fails++;
            results();
        end
    endtask : tmo

    // Readies sampled mid-cycle hold until the next edge
    task automatic wr(input logic [3:0] a, input logic [7:0] v,
                      input logic [1:0] er);
        logic ra, rw, bv;
        logic [1:0] rs;
        int k;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        bv = 0;
        for (k = 0; k < 99 && !bv; k++) begin
            @(negedge aclk);
            ra = awready;
            rw = wready;
            bv = bvalid;
            rs = bresp;
            @(posedge aclk);
            if (ra) awvalid <= 0;
            if (rw) wvalid <= 0;
        end
        bready <= 0;
        tmo(bv);
        chk("bresp", rs, er);
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] v,
                      input logic [1:0] er);
        logic g, rv;
        logic [1:0] rs;
        int k;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        rv = 0;
        for (k = 0; k < 99 && !rv; k++) begin
            @(negedge aclk);
            g = arready;
            rv = rvalid;
            v = rdata;
            rs = rresp;
            @(posedge aclk);
            if (g) arvalid <= 0;
        end
        rready <= 0;
        tmo(rv);
        chk("rresp", rs, er);
    endtask : rd

    task automatic wm(input scm_mode_t m);
        int k;
        for (k = 0; k < 3000 && mode !== m; k++) @(posedge aclk);
        chk("mode", mode, m);
        tmo(mode === m);
    endtask : wm

    task win(input int n);
        @(negedge aclk);
        nc = 0;
        ns = 0;
        nt = 0;
        np = 0;
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask : win

    task pz(input logic w);
        @(posedge aclk);
        if (w) wake_req <= 1;
        else halt_req <= 1;
        @(posedge aclk);
        wake_req <= 0;
        halt_req <= 0;
    endtask : pz

    // Main sequence
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        rd(4'h0, d, 2'b00);
        chk("mode_reg", d & 32'hfffffff3, 32'h3);
        rd(4'h4, d, 2'b00);
        chk("ctrl_reg", d, 32'h0);
        wr(4'hc, 8'h5a, 2'b10);
        rd(4'hc, d, 2'b10);
        chk("unmapped", d, 32'h0);
        // Byte lane 0 off: write answered but nothing lands
        wstrb <= 4'he;
        wr(4'h4, 8'h80, 2'b00);
        wstrb <= 4'hf;
        rd(4'h4, d, 2'b00);
        chk("no_strobe", d, 32'h0);
        $display("test registers done");
        for (c = 0; c < 8; c++) begin
            wr(4'h0, 8'(c << 5), 2'b00);
            wm(c < 2 ? MODE_SLOW_LOW_CLOCK_MODE : MODE_SLOW_DIVIDED_CLOCK_MODE);
            // Divider change waits for a tick of the old rate, up to /64
            repeat (300) @(posedge aclk);
            win(2000);
            e = c < 2 ? 50 : 500 >> (8 - c);
            chk("cpu_rate", (nc >= e-1 && nc <= e+1) ? e : nc, e);
            chk("hosc_en", hen, c > 1);
            rd(4'h8, d, 2'b00);
            chk("source", d[10:8], c < 2 ? 1 : 4);
        end
        wr(4'h0, 8'h01, 2'b00);
        wm(MODE_NORMAL);
        win(2000);
        chk("cpu_full", (nc >= 499 && nc <= 501) ? 500 : nc, 500);
        $display("test clock select done");
        for (i = 0; i < 4; i++) begin
            wr(4'h0, tm[i], 2'b00);
            wr(4'h4, tc[i], 2'b00);
            r = tm[i][0] ? MODE_NORMAL : MODE_SLOW_LOW_CLOCK_MODE;
            wm(r);
            pz(1'b0);
            wm(te[i]);
            win(400);
            chk("off_cpu", nc, 0);
            chk("sub_on", ns > 0, 1);
            chk("tbc_on", nt > 0, te[i] != MODE_SLEEP);
            chk("periph_on", np > 0, te[i] == MODE_IDLE_CLOCK_RUNNING_MODE);
            chk("hosc_idle", hen, th[i]);
            pz(1'b0);
            win(4);
            chk("halt_again", mode, te[i]);
            pz(1'b1);
            wm(r);
        end
        $display("test halt modes done");
        // Crystal straps after a mid-run reset: slow settle, fast wake
        cfg_rc <= 1'b0;
        cfg_lx <= 1'b1;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        chk("rst_mode", mode, MODE_NORMAL);
        chk("rst_hosc", hen, 1);
        rd(4'h0, d, 2'b00);
        chk("rdy_reset", d[3:2], 0);
        repeat (400) @(posedge aclk);
        rd(4'h0, d, 2'b00);
        chk("hxt_settle", d[3:2], 0);
        repeat (300) @(posedge aclk);
        rd(4'h0, d, 2'b00);
        chk("hxt_ready", d[3:2], 1);
        wr(4'h0, 8'h11, 2'b00);
        pz(1'b0);
        wm(MODE_SLEEP);
        pz(1'b1);
        wm(MODE_NORMAL);
        win(400);
        chk("bridge_cpu", (nc >= 9 && nc <= 11) ? 10 : nc, 10);
        rd(4'h8, d, 2'b00);
        chk("bridge_on", d[13], 1);
        repeat (300) @(posedge aclk);
        rd(4'h8, d, 2'b00);
        chk("bridge_off", d[13], 0);
        repeat (4200) @(posedge aclk);
        rd(4'h0, d, 2'b00);
        chk("lxt_ready", d[3:2], 3);
        $display("test straps done");
        results();
    end
endmodule : scm_clock_modes_bench
